//--- design/pvf_pkg.sv
// Purpose: shared constants for the channel voltage and foldback register bank
// Assumes: serial command interface, 14-bit voltage codes from the measurement front end
// Notes:   command codes double as register addresses
package pvf_pkg;

    // command codes
    localparam logic [7:0] CMD_CH2_VOLT      = 8'h36;
    localparam logic [7:0] CMD_CH3_VOLT      = 8'h3A;
    localparam logic [7:0] CMD_CH4_VOLT      = 8'h3E;
    localparam logic [7:0] CMD_FOLDBACK      = 8'h40;

    // field layout
    localparam int         VOLT_W            = 14;
    localparam int         FB_LSB            = 4;
    localparam int         FB_W              = 4;
    localparam int         NUM_VCH           = 3;

    // reset values
    localparam logic [13:0] VOLT_RESET       = 14'h0000;
    localparam logic [3:0]  FB_RESET         = 4'h0;
    localparam logic [7:0]  PAD_ZERO         = 8'h00;

    // scaling of a voltage count
    localparam real         VSTEP_MV         = 3.662;
    localparam real         VFULL_SCALE_V    = 60.0;

    // default limit codes handed to the current-limit circuit
    localparam logic [7:0]  LIMIT_NORMAL     = 8'h10;
    localparam logic [7:0]  LIMIT_DOUBLE     = 8'h20;

    // default 7-bit serial address, arbitrary
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h20;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_CMD,
        ST_ACK_CMD,
        ST_WDATA,
        ST_ACK_W,
        ST_RDATA,
        ST_ACK_R
    } pvf_state_type;

endpackage

//--- design/pvf_volt_chan.sv
// Purpose: one channel voltage result: supply minus drain, zero while off
// Assumes: codes arrive on the system clock with a one-cycle valid strobe
// Notes:   result already in steps of one count
`timescale 1ns/1ps
module pvf_volt_chan
    import pvf_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // measurement
    input  wire logic                meas_valid,
    input  wire logic                chan_on,
    input  wire logic [VOLT_W-1:0]   supply_code,
    input  wire logic [VOLT_W-1:0]   drain_code,
    // result
    output logic      [VOLT_W-1:0]   result
);

    typedef struct packed {
        logic [VOLT_W-1:0] res;
    } pvf_chan_type;

    pvf_chan_type st_reg;
    pvf_chan_type st_next;

    always_comb begin
        st_next = st_reg;
        if (!chan_on) begin
            st_next.res = VOLT_RESET;
        end else if (meas_valid) begin
            // drain above supply would wrap; clamp instead
            if (drain_code > supply_code) begin
                st_next.res = VOLT_RESET;
            end else begin
                st_next.res = supply_code - drain_code;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_reg <= '{res: VOLT_RESET};
        end else begin
            st_reg <= st_next;
        end
    end

    assign result = st_reg.res;

endmodule

//--- design/pvf_regs.sv
// Purpose: channel voltage telemetry and double foldback select over the serial port
// Assumes: serial lines are asynchronous, front-end codes are on CLK_SYS
// Notes:   open-drain data pin split into in, out and enable
//
// Summary of operation
// - channel 3 voltage at 3Ah, low byte first
// - channel 4 voltage at 3Eh, low byte first
// - channel 2 voltage at 36h, low byte first
// - count times 3.662 mV, 60 V span
// - measured as supply minus channel drain
// - channel off reads all zero
// - foldback select at 40h, one byte RW
// - bits 7..4 enable channels 4..1, reset zero
// - set bit doubles channel current limits
`timescale 1ns/1ps
module pvf_regs
    import pvf_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
)
(
    // clock and reset
    input  wire logic                        CLK_SYS,
    input  wire logic                        RST,
    // serial command port
    input  wire logic                        SCL_IN,
    input  wire logic                        SDA_IN,
    output logic                             SDA_OUT,
    output logic                             SDA_OE,
    // measurement front end, channels 2..4 from bit 0 up
    input  wire logic                        MEAS_VALID,
    input  wire logic [NUM_VCH-1:0]          CHAN_ON,
    input  wire logic [VOLT_W-1:0]           MAIN_SUPPLY_INPUT,
    input  wire logic [NUM_VCH*VOLT_W-1:0]   CHANNEL_FET_DRAIN,
    // foldback control, channels 1..4 from bit 0 up
    output logic      [FB_W-1:0]             DOUBLE_LIMIT_ENABLE,
    output logic      [FB_W*8-1:0]           CURRENT_LIMIT_THRESHOLD
);

    typedef struct packed {
        logic [1:0]          scl_sync;
        logic [1:0]          sda_sync;
        logic                scl_d;
        logic                sda_d;
        pvf_state_type       state;
        logic [3:0]          cnt;
        logic [7:0]          sh;
        logic                rw;
        logic                acked;
        logic [7:0]          cmd;
        logic [1:0]          bidx;
        logic [15:0]         snap;
        logic                sda_oe;
        logic                sda_out;
        logic [FB_W-1:0]     fb;
        logic [FB_W*8-1:0]   lim;
    } pvf_top_type;

    pvf_top_type st_reg;
    pvf_top_type st_next;

    logic [NUM_VCH*VOLT_W-1:0] volt;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_VCH; gi++) begin : g_ch
            pvf_volt_chan u_ch (
                .clk         (CLK_SYS),
                .rst         (RST),
                .meas_valid  (MEAS_VALID),
                .chan_on     (CHAN_ON[gi]),
                .supply_code (MAIN_SUPPLY_INPUT),
                .drain_code  (CHANNEL_FET_DRAIN[gi*VOLT_W +: VOLT_W]),
                .result      (volt[gi*VOLT_W +: VOLT_W])
            );
        end
    endgenerate

    // whole 16-bit view of the addressed register
    function automatic logic [15:0] reg_value(input logic [7:0] c, input logic [NUM_VCH*VOLT_W-1:0] v,
                                              input logic [FB_W-1:0] f);
        logic [15:0] r;
        r = 16'h0000;
        if (c == CMD_CH2_VOLT) begin
            r = {2'b00, v[0 +: VOLT_W]};
        end else if (c == CMD_CH3_VOLT) begin
            r = {2'b00, v[VOLT_W +: VOLT_W]};
        end else if (c == CMD_CH4_VOLT) begin
            r = {2'b00, v[2*VOLT_W +: VOLT_W]};
        end else if (c == CMD_FOLDBACK) begin
            r = {PAD_ZERO, f, 4'h0};
        end
        return r;
    endfunction

    function automatic logic [7:0] byte_of(input logic [15:0] s, input logic [1:0] idx);
        logic [7:0] b;
        b = PAD_ZERO;
        if (idx == 2'd0) begin
            b = s[7:0];
        end else if (idx == 2'd1) begin
            b = s[15:8];
        end
        return b;
    endfunction

    always_comb begin
        logic scl;
        logic sda;
        logic rise;
        logic fall;
        logic [15:0] sv;
        scl  = st_reg.scl_sync[1];
        sda  = st_reg.sda_sync[1];
        rise = scl & ~st_reg.scl_d;
        fall = ~scl & st_reg.scl_d;
        sv   = 16'h0000;
        st_next          = st_reg;
        st_next.scl_sync = {st_reg.scl_sync[0], SCL_IN};
        st_next.sda_sync = {st_reg.sda_sync[0], SDA_IN};
        st_next.scl_d    = scl;
        st_next.sda_d    = sda;
        st_next.sda_out  = 1'b0;

        if (scl && st_reg.scl_d && st_reg.sda_d && !sda) begin
            // start or repeated start
            st_next.state  = ST_ADDR;
            st_next.cnt    = 4'd0;
            st_next.sda_oe = 1'b0;
        end else if (scl && st_reg.scl_d && !st_reg.sda_d && sda) begin
            st_next.state  = ST_IDLE;
            st_next.sda_oe = 1'b0;
        end else begin
            case (st_reg.state)
                ST_ADDR, ST_CMD, ST_WDATA: begin
                    if (rise) begin
                        st_next.sh  = {st_reg.sh[6:0], sda};
                        st_next.cnt = st_reg.cnt + 4'd1;
                    end else if (fall && st_reg.cnt == 4'd8) begin
                        st_next.sda_oe = 1'b1;
                        if (st_reg.state == ST_ADDR) begin
                            if (st_reg.sh[7:1] == DEV_ADDR) begin
                                st_next.rw    = st_reg.sh[0];
                                st_next.state = ST_ACK_ADDR;
                            end else begin
                                st_next.sda_oe = 1'b0;
                                st_next.state  = ST_IDLE;
                            end
                        end else if (st_reg.state == ST_CMD) begin
                            st_next.cmd   = st_reg.sh;
                            st_next.bidx  = 2'd0;
                            st_next.state = ST_ACK_CMD;
                        end else begin
                            // only the first byte after the command lands; the rest is acked and dropped
                            if (st_reg.cmd == CMD_FOLDBACK && st_reg.bidx == 2'd0) begin
                                st_next.fb = st_reg.sh[FB_LSB +: FB_W];
                            end
                            if (st_reg.bidx != 2'd3) begin
                                st_next.bidx = st_reg.bidx + 2'd1;
                            end
                            st_next.state = ST_ACK_W;
                        end
                    end
                end
                ST_ACK_ADDR: begin
                    if (fall) begin
                        st_next.cnt = 4'd0;
                        if (st_reg.rw) begin
                            // snapshot keeps low and high bytes from the same sample
                            sv             = reg_value(st_reg.cmd, volt, st_reg.fb);
                            st_next.snap   = sv;
                            st_next.bidx   = 2'd0;
                            st_next.sh     = sv[7:0];
                            st_next.sda_oe = ~sv[7];
                            st_next.state  = ST_RDATA;
                        end else begin
                            st_next.sda_oe = 1'b0;
                            st_next.state  = ST_CMD;
                        end
                    end
                end
                ST_ACK_CMD, ST_ACK_W: begin
                    if (fall) begin
                        st_next.sda_oe = 1'b0;
                        st_next.cnt    = 4'd0;
                        st_next.state  = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (rise) begin
                        st_next.cnt = st_reg.cnt + 4'd1;
                    end else if (fall) begin
                        if (st_reg.cnt == 4'd8) begin
                            st_next.sda_oe = 1'b0;
                            st_next.state  = ST_ACK_R;
                        end else begin
                            st_next.sh     = {st_reg.sh[6:0], 1'b0};
                            st_next.sda_oe = ~st_reg.sh[6];
                        end
                    end
                end
                ST_ACK_R: begin
                    if (rise) begin
                        st_next.acked = ~sda;
                    end else if (fall) begin
                        if (st_reg.acked) begin
                            // high byte follows low byte; past the pair reads zero
                            st_next.bidx   = (st_reg.bidx == 2'd3) ? 2'd3 : st_reg.bidx + 2'd1;
                            st_next.sh     = byte_of(st_reg.snap, st_next.bidx);
                            st_next.sda_oe = ~st_next.sh[7];
                            st_next.cnt    = 4'd0;
                            st_next.state  = ST_RDATA;
                        end else begin
                            st_next.state = ST_IDLE;
                        end
                    end
                end
                default: begin
                    st_next.sda_oe = 1'b0;
                end
            endcase
        end

        for (int i = 0; i < FB_W; i++) begin
            st_next.lim[i*8 +: 8] = st_next.fb[i] ? LIMIT_DOUBLE : LIMIT_NORMAL;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            st_reg          <= '0;
            st_reg.scl_sync <= 2'b11;
            st_reg.sda_sync <= 2'b11;
            st_reg.scl_d    <= 1'b1;
            st_reg.sda_d    <= 1'b1;
            st_reg.state    <= ST_IDLE;
            st_reg.fb       <= FB_RESET;
            st_reg.lim      <= {FB_W{LIMIT_NORMAL}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign SDA_OUT                 = st_reg.sda_out;
    assign SDA_OE                  = st_reg.sda_oe;
    assign DOUBLE_LIMIT_ENABLE     = st_reg.fb;
    assign CURRENT_LIMIT_THRESHOLD = st_reg.lim;

endmodule

//--- bench/pvf_regs_sva.sv
// Purpose: port checker for the voltage and foldback register bank
// Assumes: host keeps clock phases of 10 cycles or more
// Notes:   one clock domain, default clocking
`timescale 1ns/1ps
module pvf_regs_sva
    import pvf_pkg::*;
(
    // clock and reset
    input wire logic                      CLK_SYS,
    input wire logic                      RST,
    // serial port
    input wire logic                      SCL_IN,
    input wire logic                      SDA_IN,
    input wire logic                      SDA_OUT,
    input wire logic                      SDA_OE,
    // front end
    input wire logic                      MEAS_VALID,
    input wire logic [NUM_VCH-1:0]        CHAN_ON,
    input wire logic [VOLT_W-1:0]         MAIN_SUPPLY_INPUT,
    input wire logic [NUM_VCH*VOLT_W-1:0] CHANNEL_FET_DRAIN,
    // foldback
    input wire logic [FB_W-1:0]           DOUBLE_LIMIT_ENABLE,
    input wire logic [FB_W*8-1:0]         CURRENT_LIMIT_THRESHOLD
);
    logic [31:0] thr_exp;
    always_comb begin
        for (int i = 0; i < FB_W; i++) begin
            thr_exp[i*8+:8] = DOUBLE_LIMIT_ENABLE[i] ? LIMIT_DOUBLE : LIMIT_NORMAL;
        end
    end
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RST);
    AST_SDA_OUT_LOW: assert property (SDA_OUT == 1'b0)
        else $error("data out not low");
    // bits must not move under a high clock
    AST_OE_STANDS: assert property ($rose(SCL_IN) |=> $stable(SDA_OE)[*8])
        else $error("data enable moved while clock high");
    AST_OE_RISE_LOW: assert property ($rose(SDA_OE) |-> !SCL_IN)
        else $error("data enable rose while clock high");
    AST_RST_FB: assert property ($fell(RST) |-> DOUBLE_LIMIT_ENABLE == FB_RESET)
        else $error("foldback bits not zero after reset");
    AST_RST_THR: assert property ($fell(RST) |-> CURRENT_LIMIT_THRESHOLD == {4{LIMIT_NORMAL}})
        else $error("limits not normal after reset");
    AST_RST_OE: assert property ($fell(RST) |-> !SDA_OE)
        else $error("data line pulled after reset");
    AST_THR_MAP: assert property (CURRENT_LIMIT_THRESHOLD == thr_exp)
        else $error("limit code does not follow foldback bit");
    AST_THR_WITH_FB: assert property ($changed(CURRENT_LIMIT_THRESHOLD) |-> $changed(DOUBLE_LIMIT_ENABLE))
        else $error("limit moved without foldback change");
    AST_FB_ON_ACK: assert property ($changed(DOUBLE_LIMIT_ENABLE) |-> ##[0:12] SDA_OE)
        else $error("foldback changed outside an acked write");
    COV_FB_WRITE: cover property ($changed(DOUBLE_LIMIT_ENABLE));
    COV_ACK: cover property ($rose(SDA_OE));
    COV_MEAS: cover property (MEAS_VALID && CHAN_ON == 3'h7);
endmodule
bind pvf_regs pvf_regs_sva u_pvf_regs_sva (.CLK_SYS(CLK_SYS), .RST(RST), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .MEAS_VALID(MEAS_VALID), .CHAN_ON(CHAN_ON),
    .MAIN_SUPPLY_INPUT(MAIN_SUPPLY_INPUT), .CHANNEL_FET_DRAIN(CHANNEL_FET_DRAIN),
    .DOUBLE_LIMIT_ENABLE(DOUBLE_LIMIT_ENABLE), .CURRENT_LIMIT_THRESHOLD(CURRENT_LIMIT_THRESHOLD));

//--- bench/pvf_host_model.sv
// Purpose: serial host that reads and writes the register bank
// Assumes: pull-up on data, host owns the clock line
// Notes:   half phases of 10 cycles, above the 8 the device needs
`timescale 1ns/1ps
module pvf_host_model #(
    parameter logic [6:0] ADDR = 7'h20
)
(
    // bus
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda
);
    int nack_cnt = 0;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hp();
        repeat (10) @(posedge clk);
    endtask
    // data moves 3 cycles after the clock falls, never with it
    task automatic bx(input logic b, output logic r);
        repeat (3) @(posedge clk);
        sda <= b;
        hp();
        scl <= 1'b1;
        hp();
        r = sda_wire;
        scl <= 1'b0;
    endtask
    task automatic start();
        repeat (3) @(posedge clk);
        sda <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda <= 1'b0;
        hp();
        scl <= 1'b0;
    endtask
    task automatic stop();
        repeat (3) @(posedge clk);
        sda <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda <= 1'b1;
        hp();
    endtask
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bx(d[i], r);
        bx(1'b1, r);
        if (r !== 1'b0) nack_cnt++;
    endtask
    task automatic rx(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
        bx(last, r);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        start();
        tx({ADDR, 1'b0});
        tx(c);
        tx(d);
        stop();
    endtask
    // low byte arrives first
    task automatic rd(input logic [7:0] c, output logic [15:0] v);
        start();
        tx({ADDR, 1'b0});
        tx(c);
        start();
        tx({ADDR, 1'b1});
        rx(1'b0, v[7:0]);
        rx(1'b1, v[15:8]);
        stop();
    endtask
endmodule

//--- bench/testbench.sv
// Purpose: directed register tests through the serial host
// Assumes: default device address
// Notes:   expected values worked out by hand from the codes driven
`timescale 1ns/1ps
module testbench;
    import pvf_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        scl;
    logic        sda;
    logic        sda_oe;
    logic        meas_valid = 1'b0;
    logic [2:0]  chan_on = 3'h0;
    logic [13:0] supply = 14'h0000;
    logic [41:0] drain = 42'h0;
    logic [3:0]  dle;
    logic [31:0] thr;
    logic [15:0] v;
    int          err_total = 0;
    int          cmp_count = 0;
    wire         sda_wire = sda & ~sda_oe;
    always #5 clk_sys = ~clk_sys;
    pvf_regs u_pvf_regs (.CLK_SYS(clk_sys), .RST(rst), .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(),
        .SDA_OE(sda_oe), .MEAS_VALID(meas_valid), .CHAN_ON(chan_on), .MAIN_SUPPLY_INPUT(supply),
        .CHANNEL_FET_DRAIN(drain), .DOUBLE_LIMIT_ENABLE(dle), .CURRENT_LIMIT_THRESHOLD(thr));
    pvf_host_model u_host (.clk(clk_sys), .sda_wire(sda_wire), .scl(scl), .sda(sda));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(thr, 32'h10101010);
        u_host.rd(CMD_FOLDBACK, v);
        chk(32'(v), 32'h00000000);
        u_host.rd(CMD_CH3_VOLT, v);
        chk(32'(v), 32'h00000000);
        u_host.wr(CMD_FOLDBACK, 8'hF0);
        chk(32'(dle), 32'h0000000F);
        chk(thr, 32'h20202020);
        u_host.wr(CMD_FOLDBACK, 8'h5F);
        chk(thr, 32'h10201020);
        u_host.rd(CMD_FOLDBACK, v);
        chk(32'(v), 32'h00000050);
        supply <= 14'h3FFF;
        drain <= {14'h0000, 14'h1234, 14'h0001};
        chan_on <= 3'h7;
        meas_valid <= 1'b1;
        @(posedge clk_sys);
        meas_valid <= 1'b0;
        u_host.rd(CMD_CH2_VOLT, v);
        chk(32'(v), 32'h00003FFE);
        u_host.rd(CMD_CH3_VOLT, v);
        chk(32'(v), 32'h00002DCB);
        u_host.rd(CMD_CH4_VOLT, v);
        chk(32'(v), 32'h00003FFF);
        // channel 3 off, old count must not leak
        chan_on <= 3'h5;
        u_host.rd(CMD_CH3_VOLT, v);
        chk(32'(v), 32'h00000000);
        u_host.rd(CMD_CH4_VOLT, v);
        chk(32'(v), 32'h00003FFF);
        // read-only result ignores a write, foldback bits untouched
        u_host.wr(CMD_CH4_VOLT, 8'h00);
        u_host.rd(CMD_CH4_VOLT, v);
        chk(32'(v), 32'h00003FFF);
        chk(32'(dle), 32'h00000005);
        chk(32'(u_host.nack_cnt), 32'h00000000);
        // mid-run reset must clear bits that were set
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(32'(dle), 32'h00000000);
        chk(thr, 32'h10101010);
        u_host.rd(CMD_CH4_VOLT, v);
        chk(32'(v), 32'h00000000);
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        give_verdict();
    end
endmodule
